// file: verilog/srcs_pkg.sv
// package: constants and types of the sequencer
package srcs_pkg;

  // ----------
  // timing counts in internal oscillator cycles, and counter sizes
  // ----------
  localparam int unsigned POR_TIMEOUT_CYC   = 4096;
  localparam int unsigned STOP_SHORT_CYC    = 32;
  localparam int unsigned PIN_DRIVE_CYC     = 32;
  localparam int unsigned INTERNAL_RESET_SIGNAL_EXTRA_CYC    = 32;
  localparam int unsigned PIN_MIN_LOW_CYC   = 67;
  localparam int unsigned PIN_MIN_POR_CYC   = 4163;
  localparam int unsigned CNT_STAGES        = 12;
  localparam int unsigned SERVICE_LOW_STAGE = 5;
  localparam int unsigned WDOG_WIDTH        = 8;

  // ----------
  // AXI4-Lite register map (byte addresses)
  // ----------
  localparam logic [7:0] CAUSE_OFFS   = 8'h00;
  localparam logic [7:0] OPTION_OFFS  = 8'h04;
  localparam logic [7:0] STATUS_OFFS  = 8'h08;
  localparam logic [7:0] VECTOR_OFFS  = 8'h0c;
  localparam logic [7:0] SERVICE_OFFS = 8'h10;

  // option_register_one fields
  localparam int unsigned OPT_SHORT_STOP_BIT  = 0;
  localparam int unsigned OPT_STOP_ENABLE_BIT = 1;
  localparam logic [1:0]  OPT_RESET_VAL       = 2'h0;

  // reset vectors and bus response codes
  localparam logic [15:0] VEC_USER    = 16'hfffe;
  localparam logic [15:0] VEC_MONITOR = 16'hfefe;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ----------
  // carriers
  // ----------
  typedef struct packed {
    logic power_on;
    logic pin;
    logic watchdog_flag;
    logic bad_opcode_flag;
    logic bad_fetch_address_flag;
    logic low_voltage_flag;
  } srcs_cause_t;

  typedef struct packed {
    logic illegal_opcode;
    logic stop_instr;
    logic wait_instr;
    logic opcode_fetch;
    logic unmapped_addr;
    logic wake;
  } srcs_cpu_ev_t;

  typedef enum logic [2:0] {
    SQ_RUN, SQ_LONG_HOLD, SQ_PIN_DRIVE, SQ_INTERNAL_RESET_SIGNAL_TAIL, SQ_STOP, SQ_STOP_REC
  } srcs_state_t;

endpackage

// file: verilog/srcs_sync3.sv
// three-stage synchroniser bank with agreement filter
`timescale 1ns/10ps
module srcs_sync3 #(
  parameter int unsigned W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] async_in,
  input  wire logic [W-1:0] reset_val,
  output logic      [W-1:0] level_q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // ----------
  // per-bit chain; first stage feeds only the second
  // ----------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          s1_q[i]    <= 1'b0;
          s2_q[i]    <= 1'b0;
          s3_q[i]    <= 1'b0;
          level_q[i] <= 1'b0;
        end else begin
          s1_q[i] <= async_in[i] ^ reset_val[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          if (s2_q[i] == s3_q[i]) begin
            level_q[i] <= s3_q[i];
          end
        end
      end
    end
  endgenerate
endmodule

// file: verilog/srcs_sequencer.sv
// system sequencer: clocks, reset sequencing, cause record, watchdog
// Notes on behaviour
// - bus clock is oscillator over four
// - power/low-voltage reset: clocks off, pin low
// - stop exit waits recovery delay, clocks off
// - short stop option selects 32 cycles
// - wait stops cpu clock, peripherals run
// - every reset asserts internal reset, vector
// - internal reset clears counter, pin reset not
// - each reset sets its cause flag
// - pin low 67 cycles sets pin flag
// - internal source: pin 32, reset 32 more
// - power-on: 4096 pin low, 64 later release
// - power-on sets only the power-on flag
// - watchdog overflow resets, flags, pulls pin
// - service write clears watchdog, stages 12..5
// - counter output clocks the watchdog
// - watchdog disabled only by test voltage
// - bad opcode resets; stop illegal if disabled
// - only unmapped opcode fetch resets
// - low voltage: flag, 4096 hold, 64 later
// - twelve stages plus overflow thirteenth stage
// - counter steps on oscillator falling edge
// - stop instruction clears the counter
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
module srcs_sequencer #(
  parameter int unsigned POR_CYC = srcs_pkg::POR_TIMEOUT_CYC
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 power_on_pulse,
  input  wire logic                 low_voltage_in,
  input  wire logic                 reset_pin_i,
  output logic                      reset_pin_o,
  output logic                      reset_pin_oe,
  input  wire logic                 test_high_voltage,
  input  wire logic                 monitor_mode,
  input  wire logic                 break_state,
  input  wire srcs_pkg::srcs_cpu_ev_t cpu_ev,
  output logic                      osc_half_clock,
  output logic                      bus_clock,
  output logic                      cpu_clock_en,
  output logic                      periph_clock_en,
  output logic                      internal_reset_signal,
  output logic [15:0]               reset_vector,
  output logic                      watchdog_tick,
  input  wire logic [3:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [3:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);
  localparam int unsigned CW = srcs_pkg::CNT_STAGES + 1;
  localparam int unsigned SL = srcs_pkg::SERVICE_LOW_STAGE;

  // ----------
  // synchronised pin, watchdog disable and low-voltage levels
  // ----------
  logic [2:0] sync_lvl;
  logic       pin_low;
  logic       lv_lvl;
  logic       tst_lvl;
  srcs_sync3 #(.W(3)) u_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .async_in  ({reset_pin_i | reset_pin_oe, low_voltage_in,
                 test_high_voltage}),
    .reset_val (3'h4),
    .level_q   (sync_lvl)
  );
  assign pin_low = sync_lvl[2];
  assign lv_lvl  = sync_lvl[1];
  assign tst_lvl = sync_lvl[0];

  // ----------
  // clocks: oscillator/2 then /2 again
  // ----------
  logic half_q;
  logic quarter_q;
  logic fall;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_q    <= 1'b0;
      quarter_q <= 1'b0;
    end else begin
      half_q <= ~half_q;
      if (half_q) begin
        quarter_q <= ~quarter_q;
      end
    end
  end
  // falling edge modelled as the half phase
  assign fall = half_q;

  // ----------
  // option register and state
  // ----------
  logic [1:0]            opt_q;
  srcs_pkg::srcs_cause_t cause_q;
  srcs_pkg::srcs_state_t st_q;
  logic [CW-1:0]         cnt_q;
  logic [12:0]           hold_q;
  logic [12:0]           pin_cnt_q;
  logic [srcs_pkg::WDOG_WIDTH-1:0] wd_q;
  logic                  wd_ovf;
  logic                  service;
  logic                  por_seen_q;
  logic                  stop_legal;
  logic                  bad_op;
  logic                  bad_fetch;
  logic                  int_src;
  logic [12:0]           stop_lim;

  assign stop_legal = opt_q[srcs_pkg::OPT_STOP_ENABLE_BIT];
  assign bad_op     = cpu_ev.illegal_opcode |
                      (cpu_ev.stop_instr & ~stop_legal);
  assign bad_fetch  = cpu_ev.opcode_fetch & cpu_ev.unmapped_addr;
  assign stop_lim   = opt_q[srcs_pkg::OPT_SHORT_STOP_BIT] ?
                      13'(srcs_pkg::STOP_SHORT_CYC) :
                      13'(srcs_pkg::POR_TIMEOUT_CYC);
  // only combinational test-voltage qualification can mask the watchdog
  assign wd_ovf     = (&wd_q) & cnt_q[CW-1] & fall &
                      ~(tst_lvl & (monitor_mode | break_state));
  assign int_src    = bad_op | bad_fetch | wd_ovf;

  // ----------
  // sequencing state machine
  // ----------
  logic long_start;
  logic lv_prev_q;
  assign long_start = power_on_pulse | (lv_lvl & ~lv_prev_q);
  always_ff @(posedge aclk) begin
    lv_prev_q <= aresetn & lv_lvl;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q   <= srcs_pkg::SQ_LONG_HOLD;
      hold_q <= 13'h0000;
    end else if (long_start) begin
      st_q   <= srcs_pkg::SQ_LONG_HOLD;
      hold_q <= 13'h0000;
    end else begin
      case (st_q)
        srcs_pkg::SQ_RUN: begin
          hold_q <= 13'h0000;
          if (int_src) begin
            st_q <= srcs_pkg::SQ_PIN_DRIVE;
          end else if (pin_low) begin
            st_q <= srcs_pkg::SQ_INTERNAL_RESET_SIGNAL_TAIL;
          end else if (cpu_ev.stop_instr && stop_legal) begin
            st_q <= srcs_pkg::SQ_STOP;
          end
        end
        srcs_pkg::SQ_LONG_HOLD: begin
          hold_q <= hold_q + 13'h0001;
          if (hold_q == 13'(POR_CYC - 1)) begin
            st_q   <= srcs_pkg::SQ_INTERNAL_RESET_SIGNAL_TAIL;
            hold_q <= 13'h0000;
          end
        end
        srcs_pkg::SQ_PIN_DRIVE: begin
          hold_q <= hold_q + 13'h0001;
          if (hold_q == 13'(srcs_pkg::PIN_DRIVE_CYC - 1)) begin
            st_q   <= srcs_pkg::SQ_INTERNAL_RESET_SIGNAL_TAIL;
            hold_q <= 13'(srcs_pkg::INTERNAL_RESET_SIGNAL_EXTRA_CYC);
          end
        end
        srcs_pkg::SQ_INTERNAL_RESET_SIGNAL_TAIL: begin
          // pin resets hold here while the pin is low
          if (pin_low) begin
            hold_q <= 13'h0000;
          end else begin
            hold_q <= hold_q + 13'h0001;
          end
          if (!pin_low &&
              hold_q == 13'(2 * srcs_pkg::INTERNAL_RESET_SIGNAL_EXTRA_CYC - 1)) begin
            st_q <= srcs_pkg::SQ_RUN;
          end
        end
        srcs_pkg::SQ_STOP: begin
          hold_q <= 13'h0000;
          if (cpu_ev.wake || pin_low) begin
            st_q <= srcs_pkg::SQ_STOP_REC;
          end
        end
        srcs_pkg::SQ_STOP_REC: begin
          hold_q <= hold_q + 13'h0001;
          if (hold_q == stop_lim - 13'h0001) begin
            st_q <= pin_low ? srcs_pkg::SQ_INTERNAL_RESET_SIGNAL_TAIL : srcs_pkg::SQ_RUN;
            hold_q <= 13'h0000;
          end
        end
        default: st_q <= srcs_pkg::SQ_RUN;
      endcase
    end
  end

  // ----------
  // stabilisation counter and watchdog
  // ----------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
    end else if (int_src || long_start ||
                 (st_q == srcs_pkg::SQ_RUN && cpu_ev.stop_instr)) begin
      cnt_q <= '0;
    end else if (service) begin
      cnt_q <= {1'b0, 8'h00, cnt_q[SL-2:0]};
    end else if (fall) begin
      // thirteenth stage restarts the twelve counting stages
      cnt_q <= cnt_q[CW-1] ? '0 : cnt_q + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wd_q <= '0;
    end else if (service || st_q != srcs_pkg::SQ_RUN) begin
      wd_q <= '0;
    end else if (cnt_q[CW-1] && fall) begin
      wd_q <= wd_q + 1'b1;
    end
  end

  // ----------
  // reset cause record
  // ----------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_cnt_q  <= 13'h0000;
      por_seen_q <= 1'b0;
    end else begin
      if (power_on_pulse) begin
        por_seen_q <= 1'b1;
      end else if (st_q == srcs_pkg::SQ_RUN) begin
        por_seen_q <= 1'b0;
      end
      if (!pin_low) begin
        pin_cnt_q <= 13'h0000;
      end else if (pin_cnt_q != 13'h1fff) begin
        pin_cnt_q <= pin_cnt_q + 13'h0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause_q <= '0;
    end else if (power_on_pulse) begin
      cause_q          <= '0;
      cause_q.power_on <= 1'b1;
    end else begin
      if (wd_ovf) cause_q.watchdog_flag <= 1'b1;
      if (bad_op) cause_q.bad_opcode_flag <= 1'b1;
      if (bad_fetch) cause_q.bad_fetch_address_flag <= 1'b1;
      if (lv_lvl) cause_q.low_voltage_flag <= 1'b1;
      if (pin_low && reset_pin_oe == 1'b0 &&
          pin_cnt_q == 13'(por_seen_q ? srcs_pkg::PIN_MIN_POR_CYC - 1 :
                                        srcs_pkg::PIN_MIN_LOW_CYC - 1)) begin
        cause_q.pin <= 1'b1;
      end
    end
  end

  // ----------
  // registered outputs
  // ----------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_half_clock        <= 1'b0;
      bus_clock             <= 1'b0;
      cpu_clock_en          <= 1'b0;
      periph_clock_en       <= 1'b0;
      internal_reset_signal <= 1'b1;
      reset_pin_o           <= 1'b0;
      reset_pin_oe          <= 1'b1;
      reset_vector          <= srcs_pkg::VEC_USER;
      watchdog_tick         <= 1'b0;
    end else begin
      osc_half_clock  <= half_q;
      bus_clock       <= quarter_q & (st_q == srcs_pkg::SQ_RUN);
      cpu_clock_en    <= st_q == srcs_pkg::SQ_RUN && !cpu_ev.wait_instr;
      periph_clock_en <= st_q == srcs_pkg::SQ_RUN;
      internal_reset_signal <= st_q == srcs_pkg::SQ_LONG_HOLD ||
                               st_q == srcs_pkg::SQ_PIN_DRIVE ||
                               st_q == srcs_pkg::SQ_INTERNAL_RESET_SIGNAL_TAIL;
      reset_pin_o  <= 1'b0;
      reset_pin_oe <= st_q == srcs_pkg::SQ_LONG_HOLD ||
                      st_q == srcs_pkg::SQ_PIN_DRIVE;
      reset_vector <= monitor_mode ? srcs_pkg::VEC_MONITOR :
                                     srcs_pkg::VEC_USER;
      watchdog_tick <= cnt_q[CW-1] & fall;
    end
  end

  // ----------
  // AXI4-Lite slave
  // ----------
  logic aw_q;
  logic w_q;
  logic [3:0] awa_q;
  logic [31:0] wd_data_q;
  logic wr_ok;
  assign wr_ok = awa_q == srcs_pkg::OPTION_OFFS[3:0] ||
                 awa_q == srcs_pkg::SERVICE_OFFS[3:0];
  // any write to the service word counts; data is ignored
  assign service = aw_q && w_q && !s_axi_bvalid &&
                   awa_q == srcs_pkg::SERVICE_OFFS[3:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q          <= 1'b0;
      w_q           <= 1'b0;
      awa_q         <= 4'h0;
      wd_data_q     <= 32'h0000_0000;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= srcs_pkg::RESP_OKAY;
      opt_q         <= srcs_pkg::OPT_RESET_VAL;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q          <= 1'b1;
        awa_q         <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q          <= 1'b1;
        wd_data_q    <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      if (aw_q && w_q && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? srcs_pkg::RESP_OKAY : srcs_pkg::RESP_SLVERR;
        if (awa_q == srcs_pkg::OPTION_OFFS[3:0] && s_axi_wstrb[0]) begin
          opt_q <= wd_data_q[1:0];
        end
      end
      if (internal_reset_signal) begin
        opt_q <= srcs_pkg::OPT_RESET_VAL;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_q          <= 1'b0;
        w_q           <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= srcs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= srcs_pkg::RESP_OKAY;
      if (s_axi_araddr == srcs_pkg::CAUSE_OFFS[3:0]) begin
        s_axi_rdata <= {26'h0, cause_q};
      end else if (s_axi_araddr == srcs_pkg::OPTION_OFFS[3:0]) begin
        s_axi_rdata <= {30'h0, opt_q};
      end else if (s_axi_araddr == srcs_pkg::STATUS_OFFS[3:0]) begin
        s_axi_rdata <= {16'h0, wd_q, 5'h0, 3'(st_q)};
      end else if (s_axi_araddr == srcs_pkg::VECTOR_OFFS[3:0]) begin
        s_axi_rdata <= {16'h0, reset_vector};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= srcs_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

// file: verification/srcs_pin_model.sv
// partner model: reset pin with pull-up and an outside reset source
`timescale 1ns/10ps
module srcs_pin_model (
  input  wire logic        aclk,
  input  wire logic        go,
  input  wire logic [12:0] len,
  input  wire logic        reset_pin_o,
  input  wire logic        reset_pin_oe,
  output logic             pin_level,
  output logic             busy
);
  logic [12:0] cnt_q = 13'h0;

  // outside source holds the pin low
  always_ff @(posedge aclk) begin
    if (go) begin
      cnt_q <= len;
    end else if (cnt_q != 13'h0) begin
      cnt_q <= cnt_q - 13'h1;
    end
  end

  assign busy = (cnt_q != 13'h0);
  // released pin goes to the pull-up level
  assign pin_level = busy ? 1'b0 : (reset_pin_oe ? reset_pin_o : 1'b1);
endmodule

// file: verification/srcs_sequencer_asserts.sv
// checker: timing relations at the ports of the system sequencer
`timescale 1ns/10ps
module srcs_sequencer_asserts #(
  parameter int unsigned POR_CYC = 64
) (
  input wire logic                   aclk,
  input wire logic                   aresetn,
  input wire srcs_pkg::srcs_cpu_ev_t cpu_ev,
  input wire logic                   monitor_mode,
  input wire logic                   reset_pin_oe,
  input wire logic                   cpu_clock_en,
  input wire logic                   periph_clock_en,
  input wire logic                   internal_reset_signal,
  input wire logic [15:0]            reset_vector,
  input wire logic                   bus_clock,
  input wire logic                   osc_half_clock,
  input wire logic                   watchdog_tick
);
  // ----------
  // helper logic
  // ----------
  logic [15:0] oe_len_q;
  logic [1:0]  up_q;
  logic        run;
  assign run = periph_clock_en && !internal_reset_signal && !reset_pin_oe;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oe_len_q <= 16'h0;
    end else if (reset_pin_oe) begin
      oe_len_q <= oe_len_q + 16'h1;
    end else begin
      oe_len_q <= 16'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up_q <= 2'h0;
    end else if (up_q != 2'h3) begin
      up_q <= up_q + 2'h1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----------
  // assertions
  // ----------
  a_half_clock_rate: assert property (
    periph_clock_en && $past(periph_clock_en) |->
      osc_half_clock != $past(osc_half_clock))
    else $error("half clock did not toggle");
  a_bus_quarter: assert property (
    periph_clock_en && $past(periph_clock_en, 4) |->
      bus_clock == $past(bus_clock, 4) && bus_clock != $past(bus_clock, 2))
    else $error("bus clock rate");
  a_hold_clocks_off: assert property (
    internal_reset_signal |-> !cpu_clock_en && !periph_clock_en)
    else $error("clocks active during reset");
  a_wait_cpu_off: assert property (
    cpu_ev.wait_instr [*2] ##0 periph_clock_en |-> !cpu_clock_en)
    else $error("cpu clock running in wait");
  a_bad_opcode_rst: assert property (
    cpu_ev.illegal_opcode && run |-> ##2 reset_pin_oe)
    else $error("bad opcode no drive");
  a_fetch_miss_rst: assert property (
    cpu_ev.opcode_fetch && cpu_ev.unmapped_addr && run |-> ##2 reset_pin_oe)
    else $error("bad fetch no drive");
  a_pin_drive_len: assert property (
    $fell(reset_pin_oe) |-> oe_len_q == 16'h20 ||
      oe_len_q == 16'(POR_CYC) || oe_len_q == 16'(POR_CYC + 1))
    else $error("pin drive length wrong");
  a_short_tail: assert property (
    $fell(reset_pin_oe) && oe_len_q == 16'h20 |->
      ##31 internal_reset_signal ##1 !internal_reset_signal)
    else $error("short tail length");
  a_long_tail: assert property (
    $fell(reset_pin_oe) && oe_len_q != 16'h20 |->
      ##63 internal_reset_signal ##1 !internal_reset_signal)
    else $error("long tail length");
  a_vector_sel: assert property (
    up_q == 2'h3 && $stable(monitor_mode) |-> reset_vector ==
      (monitor_mode ? srcs_pkg::VEC_MONITOR : srcs_pkg::VEC_USER))
    else $error("reset vector wrong for mode");
  a_tick_single: assert property (
    watchdog_tick |=> !watchdog_tick)
    else $error("tick too long");

  c_short_drive: cover property ($fell(reset_pin_oe) && oe_len_q == 16'h20);
  c_wait: cover property (cpu_ev.wait_instr && periph_clock_en);
  c_tick: cover property (watchdog_tick);
endmodule

// file: verification/system_reset_clock_sequencer_test.sv
// testbench for the system sequencer
`timescale 1ns/10ps
module system_reset_clock_sequencer_test;
  localparam int unsigned PC = 64;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic power_on_pulse = 1'b0;
  logic low_voltage_in = 1'b0;
  logic monitor_mode = 1'b0;
  logic pin_go = 1'b0;
  logic reset_pin_i, reset_pin_o, reset_pin_oe, pin_busy;
  logic osc_half_clock, bus_clock, cpu_clock_en, periph_clock_en;
  logic internal_reset_signal, watchdog_tick;
  logic [15:0] reset_vector;
  srcs_pkg::srcs_cpu_ev_t cpu_ev = '0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int n_errors = 0;
  int n_checks = 0;

  srcs_sequencer #(.POR_CYC(PC)) dut_u (
    .aclk, .aresetn, .power_on_pulse, .low_voltage_in, .reset_pin_i,
    .reset_pin_o, .reset_pin_oe, .test_high_voltage(1'b0), .monitor_mode,
    .break_state(1'b0), .cpu_ev, .osc_half_clock, .bus_clock, .cpu_clock_en,
    .periph_clock_en, .internal_reset_signal, .reset_vector, .watchdog_tick,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  srcs_pin_model pin_u (.aclk, .go(pin_go), .len(13'h46), .reset_pin_o,
    .reset_pin_oe, .pin_level(reset_pin_i), .busy(pin_busy));

  always #20 aclk = ~aclk;

  // ----------
  // reporting
  // ----------
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic hang(input string nm);
    $display("mismatch %s expected done seen timeout", nm);
    n_errors++;
    summarize();
  endtask

  // ----------
  // bus and event drivers
  // ----------
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    int i;
    logic b;
    b = 1'b0;
    r = 2'h3;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 64 && !b; i++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        b = 1'b1;
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
    if (!b) hang("write");
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    int i;
    logic got;
    got = 1'b0;
    d = 32'h0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 64 && !got; i++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        got = 1'b1;
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
      end
    end
    if (!got) hang("read");
  endtask

  task automatic ev(input logic [5:0] v);
    cpu_ev <= srcs_pkg::srcs_cpu_ev_t'(v);
    @(posedge aclk);
    cpu_ev <= '0;
  endtask

  task automatic wait_run();
    int i;
    repeat (4) @(posedge aclk);
    for (i = 0; i < 1000 && !(periph_clock_en === 1'b1 &&
         internal_reset_signal === 1'b0); i++) @(posedge aclk);
    if (i == 1000) hang("run");
  endtask

  initial begin
    repeat (100000) @(posedge aclk);
    hang("run time");
  end

  // ----------
  // scenarios
  // ----------
  initial begin
    logic [1:0] r;
    logic [31:0] d;
    int k, n;
    int kind [7] = '{0, 1, 0, 2, 3, 4, 5};
    logic [5:0] cause [7] = '{6'h20, 6'h24, 6'h20, 6'h24, 6'h26, 6'h27,
                               6'h37};
    int lo [2] = '{32, 4096};
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    wait_run();
    axi_rd(4'h4, d);
    chk("option reset", 32'h0, d);
    for (k = 0; k < 7; k++) begin
      axi_wr(4'h4, (kind[k] == 2) ? 32'h1 : 32'h3, r);
      chk("option wresp", 32'(srcs_pkg::RESP_OKAY), 32'(r));
      case (kind[k])
        0: begin
          power_on_pulse <= 1'b1;
          @(posedge aclk);
          power_on_pulse <= 1'b0;
        end
        1: ev(6'h20);
        2: ev(6'h10);
        3: ev(6'h06);
        4: begin
          low_voltage_in <= 1'b1;
          repeat (8) @(posedge aclk);
          low_voltage_in <= 1'b0;
        end
        default: begin
          pin_go <= 1'b1;
          @(posedge aclk);
          pin_go <= 1'b0;
          repeat (72) @(posedge aclk);
        end
      endcase
      wait_run();
      axi_rd(4'h0, d);
      chk("cause", 32'(cause[k]), d);
      axi_rd(4'h4, d);
      chk("option after reset", 32'h0, d);
    end
    ev(6'h02);
    n = 0;
    for (k = 0; k < 8; k++) begin
      @(posedge aclk);
      if (reset_pin_oe !== 1'b0) n++;
    end
    chk("data miss drive", 32'h0, n);
    cpu_ev <= srcs_pkg::srcs_cpu_ev_t'(6'h08);
    repeat (4) @(posedge aclk);
    chk("wait cpu clock", 32'h0, 32'(cpu_clock_en));
    chk("wait periph clock", 32'h1, 32'(periph_clock_en));
    cpu_ev <= '0;
    for (k = 0; k < 2; k++) begin
      axi_wr(4'h4, (k == 0) ? 32'h3 : 32'h2, r);
      ev(6'h10);
      repeat (4) @(posedge aclk);
      chk("stop periph clock", 32'h0, 32'(periph_clock_en));
      ev(6'h01);
      for (n = 0; n < 5000 && cpu_clock_en !== 1'b1; n++) @(posedge aclk);
      chk("stop recovery", 32'h1, n >= lo[k] && n <= lo[k] + 8);
    end
    axi_rd(4'h0, d);
    chk("cause after stop", 32'h37, d);
    monitor_mode <= 1'b1;
    repeat (2) @(posedge aclk);
    chk("monitor vector", 32'(srcs_pkg::VEC_MONITOR), reset_vector);
    monitor_mode <= 1'b0;
    repeat (2) @(posedge aclk);
    chk("user vector", 32'(srcs_pkg::VEC_USER), reset_vector);
    axi_wr(4'h8, 32'hffff, r);
    chk("status wresp", 32'(srcs_pkg::RESP_SLVERR), 32'(r));
    axi_wr(4'hc, 32'h0, r);
    chk("vector wresp", 32'(srcs_pkg::RESP_SLVERR), 32'(r));
    for (n = 0; n < 8400 && watchdog_tick !== 1'b1; n++) @(posedge aclk);
    chk("watchdog tick", 32'h1, n < 8400);
    axi_wr(4'h0, 32'h0, r);
    axi_rd(4'h8, d);
    chk("service clears watchdog", 32'h0, {24'h0, d[15:8]});
    summarize();
  end
endmodule

bind srcs_sequencer srcs_sequencer_asserts #(.POR_CYC(POR_CYC)) chk_u (
  .aclk, .aresetn, .cpu_ev, .monitor_mode, .reset_pin_oe, .cpu_clock_en,
  .periph_clock_en, .internal_reset_signal, .reset_vector, .bus_clock,
  .osc_half_clock, .watchdog_tick);
